// ### hdl/adcpop_pkg.sv
package adcpop_pkg;
	// ----------------------------------------------------------------
	// Word layout
	// ----------------------------------------------------------------
	localparam int DATA_W = 14;
	localparam int MSB_POS = 13;
	localparam int LSB_POS = 0;
	localparam int ORNG_POS = 14;
	localparam int ENTRY_W = 15;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int LATENCY = 8;
	localparam int REF_CLK_HZ = 50_000_000;
	localparam int SETTLE_TIME_MS = 10;
	localparam int SETTLE_CYCLES = SETTLE_TIME_MS * (REF_CLK_HZ / 1000);
	localparam int SETTLE_W = 20;
	localparam int PERIOD_W = 8;
	localparam logic [PERIOD_W-1:0] PERIOD_MAX = 8'hFF;
	localparam logic [PERIOD_W-1:0] HALF_MIN = 8'h01;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] WORD_RST = 14'h0000;
	localparam logic FMT_TWOS = 1'b0;
	localparam logic FMT_GRAY = 1'b1;

	typedef enum logic [1:0] {
		ADCPOP_SLEEP,
		ADCPOP_SETTLE,
		ADCPOP_RUN
	} adcpop_state_t;
endpackage

// ### hdl/adcpop_fifo.sv
`timescale 1ns/10ps
module adcpop_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i,
	output logic [$clog2(DEPTH+1)-1:0] level_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int LW = $clog2(DEPTH+1);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
	localparam logic [LW-1:0] LVL_FULL = LW'(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [LW-1:0] lvl_reg, lvl_next;
	logic push, pop;

	assign out_valid_o = (lvl_reg != '0);
	assign in_ready_o = (lvl_reg != LVL_FULL) || out_ready_i;
	assign out_data_o = mem_reg[rd_reg];
	assign level_o = lvl_reg;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		mem_next = mem_reg;
		wr_next = wr_reg;
		rd_next = rd_reg;
		lvl_next = lvl_reg;
		if (flush_i) begin
			wr_next = '0;
			rd_next = '0;
			lvl_next = '0;
		end else begin
			if (push) begin
				mem_next[wr_reg] = in_data_i;
				wr_next = (wr_reg == PTR_LAST) ? '0 : wr_reg + 1'b1;
			end
			if (pop) begin
				rd_next = (rd_reg == PTR_LAST) ? '0 : rd_reg + 1'b1;
			end
			if (push && !pop) begin
				lvl_next = lvl_reg + 1'b1;
			end else if (pop && !push) begin
				lvl_next = lvl_reg - 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
			wr_reg <= '0;
			rd_reg <= '0;
			lvl_reg <= '0;
		end else begin
			mem_reg <= mem_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			lvl_reg <= lvl_next;
		end
	end
endmodule

// ### hdl/adcpop_port.sv
`timescale 1ns/10ps
// Overview of operation
// RL1: Conversion word is parallel, MSB on bit 13, LSB on bit 0.
// RL2: Single-ended valid strobe follows the sampling clock.
// RL3: Strobe is rebuilt at half period, hiding sampling clock duty-cycle.
// RL4: Back end latches the word on strobe edges, not the sampling clock.
// RL5: Sleep pin high puts the port into power-down; drive only when idle.
// RL6: Sleep pin low: normal operation, one new result per sampling cycle.
// RL7: Format select low gives two's complement words.
// RL8: Format select high gives Gray-coded words.
// RL9: Gray code is binary-reflected: each bit XOR of adjacent binary bits.
// RL10: Each sample appears exactly eight sampling cycles after being taken.
// RL11: After wake or power-up, data invalid for 10 ms; back end ignores it.
// RL12: Over-range flag high with any sample beyond full scale, else low.
module adcpop_port #(
	parameter int DATA_W = adcpop_pkg::DATA_W,
	parameter int LATENCY = adcpop_pkg::LATENCY,
	parameter int SETTLE_CYCLES = adcpop_pkg::SETTLE_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic sample_clk_i,
	input wire logic [DATA_W-1:0] quantizer_word_i,
	input wire logic quantizer_over_i,
	input wire logic sleep_request_pin_i,
	input wire logic format_select_i,
	output logic [DATA_W-1:0] sample_word_o,
	output logic over_range_flag_o,
	output logic sample_valid_strobe_o,
	output logic settling_o
);
	localparam int LW = $clog2(LATENCY+1);
	localparam logic [LW-1:0] LVL_LAT = LW'(LATENCY);
	localparam int SW = adcpop_pkg::SETTLE_W;
	localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE_CYCLES - 1);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
	logic slp_s1_reg, slp_s2_reg;
	logic fmt_s1_reg, fmt_s2_reg;
	logic orn_s1_reg, orn_s2_reg;
	logic [DATA_W-1:0] wrd_s1_reg, wrd_s2_reg;

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			clk_s1_reg <= 1'b0;
			clk_s2_reg <= 1'b0;
			clk_s3_reg <= 1'b0;
			slp_s1_reg <= 1'b1;
			slp_s2_reg <= 1'b1;
			fmt_s1_reg <= adcpop_pkg::FMT_TWOS;
			fmt_s2_reg <= adcpop_pkg::FMT_TWOS;
			orn_s1_reg <= 1'b0;
			orn_s2_reg <= 1'b0;
			wrd_s1_reg <= adcpop_pkg::WORD_RST;
			wrd_s2_reg <= adcpop_pkg::WORD_RST;
		end else begin
			clk_s1_reg <= sample_clk_i;
			clk_s2_reg <= clk_s1_reg;
			clk_s3_reg <= clk_s2_reg;
			slp_s1_reg <= sleep_request_pin_i;
			slp_s2_reg <= slp_s1_reg;
			fmt_s1_reg <= format_select_i;
			fmt_s2_reg <= fmt_s1_reg;
			orn_s1_reg <= quantizer_over_i;
			orn_s2_reg <= orn_s1_reg;
			wrd_s1_reg <= quantizer_word_i;
			wrd_s2_reg <= wrd_s1_reg;
		end
	end

	logic rise;
	assign rise = clk_s2_reg && !clk_s3_reg;

	// ----------------------------------------------------------------
	// Power state and reference settling
	// ----------------------------------------------------------------
	adcpop_pkg::adcpop_state_t st_reg, st_next;
	logic [adcpop_pkg::SETTLE_W-1:0] stl_reg, stl_next;

	always_comb begin
		st_next = st_reg;
		stl_next = stl_reg;
		case (st_reg)
			adcpop_pkg::ADCPOP_SLEEP: begin
				stl_next = '0;
				if (!slp_s2_reg) begin
					st_next = adcpop_pkg::ADCPOP_SETTLE;
				end
			end
			adcpop_pkg::ADCPOP_SETTLE: begin
				stl_next = stl_reg + 1'b1;
				if (slp_s2_reg) begin
					st_next = adcpop_pkg::ADCPOP_SLEEP; // RL5
				end else if (stl_reg == SETTLE_LAST) begin
					st_next = adcpop_pkg::ADCPOP_RUN; // RL11
				end
			end
			adcpop_pkg::ADCPOP_RUN: begin
				if (slp_s2_reg) begin
					st_next = adcpop_pkg::ADCPOP_SLEEP; // RL5
				end
			end
			default: begin
				st_next = adcpop_pkg::ADCPOP_SLEEP;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_reg <= adcpop_pkg::ADCPOP_SLEEP;
			stl_reg <= '0;
		end else begin
			st_reg <= st_next;
			stl_reg <= stl_next;
		end
	end

	logic awake;
	assign awake = (st_reg != adcpop_pkg::ADCPOP_SLEEP) && !slp_s2_reg;
	assign settling_o = (st_reg != adcpop_pkg::ADCPOP_RUN);

	// ----------------------------------------------------------------
	// Latency pipeline
	// ----------------------------------------------------------------
	logic fifo_in_ready, fifo_out_valid, pop, push;
	logic [adcpop_pkg::ENTRY_W-1:0] head;
	logic [LW-1:0] level;

	assign push = rise && awake && fifo_in_ready; // RL6
	assign pop = rise && awake && fifo_out_valid && (level == LVL_LAT); // RL10

	adcpop_fifo #(
		.WIDTH(adcpop_pkg::ENTRY_W),
		.DEPTH(LATENCY)
	) u_fifo (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.flush_i(!awake),
		.in_valid_i(push),
		.in_data_i({orn_s2_reg, wrd_s2_reg}),
		.in_ready_o(fifo_in_ready),
		.out_valid_o(fifo_out_valid),
		.out_data_o(head),
		.out_ready_i(pop),
		.level_o(level)
	);

	// ----------------------------------------------------------------
	// Output word encoding
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] twos, gray;
	logic [DATA_W-1:0] word_reg, word_next;
	logic orng_reg, orng_next;

	assign twos = head[DATA_W-1:0];
	assign gray = twos ^ (twos >> 1); // RL9

	always_comb begin
		word_next = word_reg;
		orng_next = orng_reg;
		if (!awake) begin
			word_next = adcpop_pkg::WORD_RST; // RL5
			orng_next = 1'b0;
		end else if (pop) begin
			word_next = (fmt_s2_reg == adcpop_pkg::FMT_GRAY) ? gray : twos; // RL7 RL8
			orng_next = head[adcpop_pkg::ORNG_POS]; // RL12
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			word_reg <= adcpop_pkg::WORD_RST;
			orng_reg <= 1'b0;
		end else begin
			word_reg <= word_next;
			orng_reg <= orng_next;
		end
	end

	assign sample_word_o = word_reg; // RL1
	assign over_range_flag_o = orng_reg;

	// ----------------------------------------------------------------
	// Duty-corrected valid strobe
	// ----------------------------------------------------------------
	logic [adcpop_pkg::PERIOD_W-1:0] per_reg, per_next, half_reg, half_next;
	logic [adcpop_pkg::PERIOD_W-1:0] hi_reg, hi_next;
	logic pop_d_reg, strb_reg, strb_next;

	always_comb begin
		per_next = per_reg;
		half_next = half_reg;
		hi_next = (hi_reg != '0) ? hi_reg - 1'b1 : hi_reg;
		if (rise) begin
			per_next = 8'h01;
			half_next = ((per_reg >> 1) > adcpop_pkg::HALF_MIN) ? (per_reg >> 1)
				: adcpop_pkg::HALF_MIN; // RL3
		end else if (per_reg != adcpop_pkg::PERIOD_MAX) begin
			per_next = per_reg + 1'b1;
		end
		if (!awake || st_reg != adcpop_pkg::ADCPOP_RUN) begin
			hi_next = '0; // RL11
		end else if (pop_d_reg) begin
			hi_next = half_reg; // RL2
		end
		strb_next = (hi_next != '0);
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			per_reg <= '0;
			half_reg <= adcpop_pkg::HALF_MIN;
			hi_reg <= '0;
			pop_d_reg <= 1'b0;
			strb_reg <= 1'b0;
		end else begin
			per_reg <= per_next;
			half_reg <= half_next;
			hi_reg <= hi_next;
			pop_d_reg <= pop;
			strb_reg <= strb_next;
		end
	end

	// Strobe rises one cycle after the word changes, so the back end latches stable data
	assign sample_valid_strobe_o = strb_reg; // RL4

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic [adcpop_pkg::PERIOD_W-1:0] hlen_reg, exp_reg;
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hlen_reg <= '0;
			exp_reg <= '0;
		end else begin
			hlen_reg <= strb_reg ? hlen_reg + 1'b1 : '0;
			exp_reg <= (pop_d_reg && strb_next) ? half_reg : exp_reg;
		end
	end

	// Output word decoded back to binary for the AST_GRAY check
	logic [DATA_W-1:0] word_bin;
	for (genvar gi = 0; gi < DATA_W; gi++) begin : g_ungray
		assign word_bin[gi] = ^sample_word_o[DATA_W-1:gi];
	end

	sequence s_wake;
		$fell(slp_s2_reg);
	endsequence
	sequence s_strobe_start;
		pop_d_reg && st_reg == adcpop_pkg::ADCPOP_RUN && !slp_s2_reg;
	endsequence
	sequence s_pop_twos;
		pop && fmt_s2_reg == adcpop_pkg::FMT_TWOS;
	endsequence
	sequence s_pop_gray;
		pop && fmt_s2_reg == adcpop_pkg::FMT_GRAY;
	endsequence

	AST_TWOS: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL7
		s_pop_twos |=> sample_word_o == $past(head[DATA_W-1:0]))
		else $error("two's complement word mismatch");
	AST_GRAY: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL8
		s_pop_gray |=> word_bin == $past(twos))
		else $error("gray word mismatch");
	AST_MSB: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL1
		s_pop_twos |=> sample_word_o[adcpop_pkg::MSB_POS] == $past(head[adcpop_pkg::MSB_POS]))
		else $error("msb misplaced");
	AST_GRAY_MSB: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL9
		s_pop_gray |=> sample_word_o[adcpop_pkg::MSB_POS] == $past(twos[adcpop_pkg::MSB_POS]))
		else $error("gray msb not binary msb");
	AST_LAT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL10
		pop |=> level == LVL_LAT)
		else $error("sample popped at wrong depth");
	AST_RUN: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL6
		rise && awake && level == LVL_LAT |-> pop ##1 pop_d_reg)
		else $error("full pipeline not advanced");
	AST_ORNG: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL12
		pop |=> over_range_flag_o == $past(head[adcpop_pkg::ORNG_POS]))
		else $error("over-range flag mismatch");
	AST_SLEEP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL5
		slp_s2_reg |=> sample_word_o == adcpop_pkg::WORD_RST && !sample_valid_strobe_o
			&& level == '0)
		else $error("outputs active in power-down");
	AST_SETTLE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL11
		s_wake |=> settling_o [*8])
		else $error("settling ended too early");
	AST_STRB: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL2
		s_strobe_start |=> sample_valid_strobe_o)
		else $error("strobe did not follow sampling edge");
	AST_DUTY: assert property (@(posedge ref_clk_i) disable iff (!nrst_i || slp_s2_reg) // RL3
		$fell(strb_reg) && !settling_o |-> $past(hlen_reg) + 1'b1 == exp_reg)
		else $error("strobe high time not half period");
	AST_QUIET: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL11
		settling_o |-> !sample_valid_strobe_o)
		else $error("strobe active while settling");
	AST_ORNG_SLEEP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL5
		slp_s2_reg |=> !over_range_flag_o)
		else $error("over-range flag active in power-down");
endmodule

// ### tb/adcpop_capture_model.sv
`timescale 1ns/10ps
module adcpop_capture_model (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic [adcpop_pkg::DATA_W-1:0] word_i,
	input wire logic over_i,
	input wire logic strobe_i,
	input wire logic settling_i,
	output logic [adcpop_pkg::DATA_W-1:0] word_o,
	output logic over_o,
	output logic got_o
);
	logic strobe_reg;

	// ----------------------------------------------------------------
	// Latch on strobe rise, drop words while settling
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			strobe_reg <= 1'b0;
			got_o <= 1'b0;
			word_o <= 14'h0000;
			over_o <= 1'b0;
		end else begin
			strobe_reg <= strobe_i;
			got_o <= 1'b0;
			if (strobe_i && !strobe_reg && !settling_i) begin
				word_o <= word_i;
				over_o <= over_i;
				got_o <= 1'b1;
			end
		end
	end
endmodule

// ### tb/adc_parallel_output_port_test.sv
`timescale 1ns/10ps
module adc_parallel_output_port_test;
	localparam int SETTLE = 64;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic sample_clk_i = 1'b0;
	logic [13:0] quantizer_word_i = 14'h0000;
	logic quantizer_over_i = 1'b0;
	logic sleep_request_pin_i = 1'b0;
	logic format_select_i = 1'b0;
	logic [13:0] word;
	logic [13:0] cap_word;
	logic over, strobe, settling, cap_over, got;
	int failures = 0;
	int tests_run = 0;
	int idx = 0;
	int gots = 0;
	int hi_cnt = 0;
	int bad_rise = 0;
	int c;
	bit chk_en = 1'b0;

	adcpop_port #(.SETTLE_CYCLES(SETTLE)) i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.sample_clk_i(sample_clk_i), .quantizer_word_i(quantizer_word_i),
		.quantizer_over_i(quantizer_over_i), .sleep_request_pin_i(sleep_request_pin_i),
		.format_select_i(format_select_i), .sample_word_o(word), .over_range_flag_o(over),
		.sample_valid_strobe_o(strobe), .settling_o(settling));

	adcpop_capture_model i_far (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .word_i(word),
		.over_i(over), .strobe_i(strobe), .settling_i(settling), .word_o(cap_word),
		.over_o(cap_over), .got_o(got));

	function automatic logic [13:0] val(input int e);
		return 14'(e * 14'h0493 + 14'h1FF0);
	endfunction

	function automatic logic [15:0] expw(input int e);
		logic [13:0] b;
		b = val(e);
		return format_select_i ? 16'(b ^ (b >> 1)) : 16'(b);
	endfunction

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clocks: uneven duty on the sampling clock
	// ----------------------------------------------------------------
	always #10 ref_clk_i = ~ref_clk_i;

	initial begin
		#20;
		forever begin
			sample_clk_i = 1'b1;
			idx++;
			#120;
			sample_clk_i = 1'b0;
			quantizer_word_i = val(idx + 1);
			quantizer_over_i = ((idx + 1) % 3 == 0);
			#40;
		end
	end

	// ----------------------------------------------------------------
	// Monitor
	// ----------------------------------------------------------------
	always @(posedge ref_clk_i) begin
		if (strobe === 1'b1) begin
			hi_cnt++;
		end else begin
			if (hi_cnt > 0 && chk_en) check("strobe_width", 16'(hi_cnt), 16'h0004);
			hi_cnt = 0;
		end
		if (strobe === 1'b1 && settling === 1'b1) bad_rise++;
		if (got === 1'b1) begin
			gots++;
			if (chk_en) begin
				check("word", 16'(cap_word), expw(idx - 8));
				check("over", 16'(cap_over), 16'((idx - 8) % 3 == 0));
			end
		end
	end

	task automatic wait_settle();
		c = 0;
		while (settling === 1'b1 && c < 1000) begin
			@(negedge ref_clk_i);
			c++;
		end
		check("settle_len", 16'(c >= SETTLE && c <= SETTLE + 4), 16'h0001);
		check("strobe_in_settle", 16'(bad_rise), 16'h0000);
	endtask

	task automatic test_reset();
		repeat (10) @(negedge ref_clk_i);
		check("rst_settling", 16'(settling), 16'h0001);
		check("rst_word", {over, strobe, word}, 16'h0000);
		repeat (10) @(negedge ref_clk_i);
		nrst_i = 1'b1;
		wait_settle();
		$display("test_reset done");
	endtask

	task automatic test_stream(input logic fmt);
		@(negedge ref_clk_i);
		format_select_i = fmt;
		repeat (12) @(posedge sample_clk_i);
		chk_en = 1'b1;
		@(posedge sample_clk_i);
		gots = 0;
		repeat (16) @(posedge sample_clk_i);
		check("words_per_cycle", 16'(gots), 16'h0010);
		chk_en = 1'b0;
		$display("test_stream format %0d done", fmt);
	endtask

	task automatic test_sleep();
		@(negedge ref_clk_i);
		sleep_request_pin_i = 1'b1;
		repeat (8) @(negedge ref_clk_i);
		bad_rise = 0;
		check("sleep_out", {over, strobe, word}, 16'h0000);
		check("sleep_settling", 16'(settling), 16'h0001);
		repeat (40) @(negedge ref_clk_i);
		sleep_request_pin_i = 1'b0;
		wait_settle();
		$display("test_sleep done");
	endtask

	initial begin
		test_reset();
		test_stream(1'b0);
		test_stream(1'b1);
		test_sleep();
		test_stream(1'b0);
		results();
	end

	initial begin
		#200000;
		failures++;
		results();
	end
endmodule
